// ==== core/hiw_hanc_window.sv ====
// Ancillary insertion window for one video output channel, with an APB register file.
// What this block does
// - An 11-bit field in the low bits holds the channel's vertical image size.
// - An 11-bit field at bits 26-16 gives the line where top-field insertion starts.
// - Line start positions are compared with a line counter that resets to 1.
// - An 11-bit field at bits 10-0 gives the pixel where top-field insertion starts.
// - Pixel start positions are compared with a pixel counter that resets to 0.
// - An 11-bit field at bits 26-16 gives the number of top-field ancillary lines.
// - An 11-bit field at bits 10-0 gives the ancillary extent on each line.
// - Separate bottom-field line and pixel starts use the same two counters.
//
// Chosen here: the APB interface to the registers and the register addresses.
`default_nettype none

module hiw_hanc_window
    import hiw_pkg::*;
#(
    parameter int unsigned FLD_W = HIW_FLD_W
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [7:0]       vid_byte,
    input  wire logic             vid_valid,
    input  wire logic [7:0]       anc_byte,
    output logic                  anc_ready,
    output logic      [7:0]       out_byte,
    output logic                  out_valid,
    output logic                  out_is_anc,
    output logic                  field_bottom,
    output logic      [FLD_W-1:0] line_count,
    output logic      [FLD_W-1:0] pixel_count
);

    // ************************************************************
    // Register file state
    // ************************************************************
    logic [FLD_W-1:0] vsize_reg,      vsize_next;
    logic [FLD_W-1:0] top_line_reg,   top_line_next;
    logic [FLD_W-1:0] top_pix_reg,    top_pix_next;
    logic [FLD_W-1:0] top_lspan_reg,  top_lspan_next;
    logic [FLD_W-1:0] top_pspan_reg,  top_pspan_next;
    logic [FLD_W-1:0] bot_line_reg,   bot_line_next;
    logic [FLD_W-1:0] bot_pix_reg,    bot_pix_next;
    logic [FLD_W-1:0] line_len_reg,   line_len_next;
    logic [1:0]       ctrl_reg,       ctrl_next;
    logic [31:0]      prdata_reg,     prdata_next;

    logic        wr_en;
    logic        rd_setup;
    logic        addr_hit;
    logic [31:0] rd_word;

    // ************************************************************
    // Counter and field state
    // ************************************************************
    hiw_state_t       state_reg,   state_next;
    logic [FLD_W-1:0] line_reg,    line_next;
    logic [FLD_W-1:0] pix_reg,     pix_next;

    // ************************************************************
    // Output byte path state
    // ************************************************************
    logic [7:0] obyte_reg,  obyte_next;
    logic       ovalid_reg, ovalid_next;
    logic       oanc_reg,   oanc_next;

    logic             chan_en;
    logic             chan_active;
    logic [FLD_W-1:0] sel_line_start;
    logic [FLD_W-1:0] sel_pix_start;
    logic             line_hit;
    logic             pix_hit;
    logic             win_hit;

    // ************************************************************
    // APB decode
    // ************************************************************
    // The slave never inserts wait states, so every access ends in its first access cycle.
    assign pready   = 1'b1;
    assign wr_en    = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pslverr  = psel & penable & ~addr_hit;

    always_comb begin
        addr_hit = 1'b1;
        rd_word  = HIW_WORD_RST;
        case (paddr)
            HIW_OFF_VSIZE: begin
                rd_word[HIW_LO_LSB +: FLD_W] = vsize_reg;
            end
            HIW_OFF_TOP_START: begin
                rd_word[HIW_HI_LSB +: FLD_W] = top_line_reg;
                rd_word[HIW_LO_LSB +: FLD_W] = top_pix_reg;
            end
            HIW_OFF_TOP_SIZE: begin
                rd_word[HIW_HI_LSB +: FLD_W] = top_lspan_reg;
                rd_word[HIW_LO_LSB +: FLD_W] = top_pspan_reg;
            end
            HIW_OFF_BOT_START: begin
                rd_word[HIW_HI_LSB +: FLD_W] = bot_line_reg;
                rd_word[HIW_LO_LSB +: FLD_W] = bot_pix_reg;
            end
            HIW_OFF_CTRL: begin
                rd_word[HIW_CTRL_EN]    = ctrl_reg[HIW_CTRL_EN];
                rd_word[HIW_CTRL_ILACE] = ctrl_reg[HIW_CTRL_ILACE];
            end
            HIW_OFF_LINE_LEN: begin
                rd_word[HIW_LO_LSB +: FLD_W] = line_len_reg;
            end
            HIW_OFF_STATUS: begin
                rd_word[HIW_STAT_FIELD]      = (state_reg == HIW_ST_BOTTOM);
                rd_word[HIW_STAT_ACTIVE]     = chan_active;
                rd_word[HIW_HI_LSB +: FLD_W] = line_reg;
                rd_word[HIW_LO_LSB +: FLD_W] = pix_reg;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // Register writes
    // ************************************************************
    // Start and size fields are stored as written; the low three bits are not
    // forced to zero, so a misaligned value shifts the window by that amount.
    always_comb begin
        vsize_next     = vsize_reg;
        top_line_next  = top_line_reg;
        top_pix_next   = top_pix_reg;
        top_lspan_next = top_lspan_reg;
        top_pspan_next = top_pspan_reg;
        bot_line_next  = bot_line_reg;
        bot_pix_next   = bot_pix_reg;
        line_len_next  = line_len_reg;
        ctrl_next      = ctrl_reg;
        if (wr_en) begin
            case (paddr)
                HIW_OFF_VSIZE: begin
                    vsize_next = pwdata[HIW_LO_LSB +: FLD_W];
                end
                HIW_OFF_TOP_START: begin
                    top_line_next = pwdata[HIW_HI_LSB +: FLD_W];
                    top_pix_next  = pwdata[HIW_LO_LSB +: FLD_W];
                end
                HIW_OFF_TOP_SIZE: begin
                    top_lspan_next = pwdata[HIW_HI_LSB +: FLD_W];
                    top_pspan_next = pwdata[HIW_LO_LSB +: FLD_W];
                end
                HIW_OFF_BOT_START: begin
                    bot_line_next = pwdata[HIW_HI_LSB +: FLD_W];
                    bot_pix_next  = pwdata[HIW_LO_LSB +: FLD_W];
                end
                HIW_OFF_CTRL: begin
                    ctrl_next[HIW_CTRL_EN]    = pwdata[HIW_CTRL_EN];
                    ctrl_next[HIW_CTRL_ILACE] = pwdata[HIW_CTRL_ILACE];
                end
                HIW_OFF_LINE_LEN: begin
                    line_len_next = pwdata[HIW_LO_LSB +: FLD_W];
                end
                default: begin
                    ctrl_next = ctrl_reg;
                end
            endcase
        end
        prdata_next = rd_setup ? rd_word : prdata_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vsize_reg     <= HIW_FIELD_RST;
            top_line_reg  <= HIW_FIELD_RST;
            top_pix_reg   <= HIW_FIELD_RST;
            top_lspan_reg <= HIW_FIELD_RST;
            top_pspan_reg <= HIW_FIELD_RST;
            bot_line_reg  <= HIW_FIELD_RST;
            bot_pix_reg   <= HIW_FIELD_RST;
            line_len_reg  <= HIW_LINE_LEN_RST;
            ctrl_reg      <= HIW_CTRL_RST;
            prdata_reg    <= HIW_WORD_RST;
        end else begin
            vsize_reg     <= vsize_next;
            top_line_reg  <= top_line_next;
            top_pix_reg   <= top_pix_next;
            top_lspan_reg <= top_lspan_next;
            top_pspan_reg <= top_pspan_next;
            bot_line_reg  <= bot_line_next;
            bot_pix_reg   <= bot_pix_next;
            line_len_reg  <= line_len_next;
            ctrl_reg      <= ctrl_next;
            prdata_reg    <= prdata_next;
        end
    end

    assign prdata = prdata_reg;

    // ************************************************************
    // Line and pixel counters with field tracking
    // ************************************************************
    // Clearing the enable parks both counters at their reset values, so a new
    // frame always starts at line 1, pixel 0 in the top field.
    assign chan_en     = ctrl_reg[HIW_CTRL_EN];
    assign chan_active = (state_reg != HIW_ST_IDLE);

    always_comb begin
        state_next = state_reg;
        line_next  = line_reg;
        pix_next   = pix_reg;
        case (state_reg)
            HIW_ST_IDLE: begin
                line_next = HIW_LINE_CNT_RST;
                pix_next  = HIW_PIX_CNT_RST;
                if (chan_en) begin
                    state_next = HIW_ST_TOP;
                end
            end
            HIW_ST_TOP, HIW_ST_BOTTOM: begin
                if (!chan_en) begin
                    state_next = HIW_ST_IDLE;
                    line_next  = HIW_LINE_CNT_RST;
                    pix_next   = HIW_PIX_CNT_RST;
                end else if (vid_valid) begin
                    if (pix_reg >= line_len_reg) begin
                        pix_next = HIW_PIX_CNT_RST;
                        if (line_reg >= vsize_reg) begin
                            // The image size counts lines of one field.
                            line_next = HIW_LINE_CNT_RST;
                            if (ctrl_reg[HIW_CTRL_ILACE] && state_reg == HIW_ST_TOP) begin
                                state_next = HIW_ST_BOTTOM;
                            end else begin
                                state_next = HIW_ST_TOP;
                            end
                        end else begin
                            line_next = line_reg + 1'b1;
                        end
                    end else begin
                        pix_next = pix_reg + 1'b1;
                    end
                end
            end
            default: begin
                state_next = HIW_ST_IDLE;
                line_next  = HIW_LINE_CNT_RST;
                pix_next   = HIW_PIX_CNT_RST;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= HIW_ST_IDLE;
            line_reg  <= HIW_LINE_CNT_RST;
            pix_reg   <= HIW_PIX_CNT_RST;
        end else begin
            state_reg <= state_next;
            line_reg  <= line_next;
            pix_reg   <= pix_next;
        end
    end

    assign field_bottom = (state_reg == HIW_ST_BOTTOM);
    assign line_count   = line_reg;
    assign pixel_count  = pix_reg;

    // ************************************************************
    // Insertion window
    // ************************************************************
    // Both fields share the top-field spans, since the bottom field has no
    // span settings of its own in this block.
    always_comb begin
        if (state_reg == HIW_ST_BOTTOM) begin
            sel_line_start = bot_line_reg;
            sel_pix_start  = bot_pix_reg;
        end else begin
            sel_line_start = top_line_reg;
            sel_pix_start  = top_pix_reg;
        end
    end

    hiw_span_check #(
        .W (FLD_W)
    ) u_line_span (
        .count (line_reg),
        .start (sel_line_start),
        .size  (top_lspan_reg),
        .hit   (line_hit)
    );

    hiw_span_check #(
        .W (FLD_W)
    ) u_pix_span (
        .count (pix_reg),
        .start (sel_pix_start),
        .size  (top_pspan_reg),
        .hit   (pix_hit)
    );

    assign win_hit   = chan_active & line_hit & pix_hit;
    assign anc_ready = win_hit & vid_valid;

    // ************************************************************
    // Output byte path
    // ************************************************************
    // A byte is tagged with the counter position it was accepted at and
    // leaves one cycle later; disabled channels pass video straight through.
    always_comb begin
        obyte_next  = obyte_reg;
        ovalid_next = vid_valid;
        oanc_next   = vid_valid & win_hit;
        if (vid_valid) begin
            obyte_next = win_hit ? anc_byte : vid_byte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            obyte_reg  <= HIW_BYTE_RST;
            ovalid_reg <= 1'b0;
            oanc_reg   <= 1'b0;
        end else begin
            obyte_reg  <= obyte_next;
            ovalid_reg <= ovalid_next;
            oanc_reg   <= oanc_next;
        end
    end

    assign out_byte   = obyte_reg;
    assign out_valid  = ovalid_reg;
    assign out_is_anc = oanc_reg;

endmodule

`default_nettype wire

// ==== core/hiw_pkg.sv ====
// Package with register map, field layout and reset values of the ancillary window block.
`default_nettype none

package hiw_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int unsigned HIW_ADDR_W = 8;
    localparam logic [7:0] HIW_OFF_VSIZE     = 8'h00;
    localparam logic [7:0] HIW_OFF_TOP_START = 8'h04;
    localparam logic [7:0] HIW_OFF_TOP_SIZE  = 8'h08;
    localparam logic [7:0] HIW_OFF_BOT_START = 8'h0C;
    localparam logic [7:0] HIW_OFF_CTRL      = 8'h10;
    localparam logic [7:0] HIW_OFF_LINE_LEN  = 8'h14;
    localparam logic [7:0] HIW_OFF_STATUS    = 8'h18;

    // ************************************************************
    // Field layout
    // ************************************************************
    localparam int unsigned HIW_FLD_W       = 11;
    localparam int unsigned HIW_LO_LSB      = 0;
    localparam int unsigned HIW_HI_LSB      = 16;
    localparam int unsigned HIW_CTRL_EN     = 0;
    localparam int unsigned HIW_CTRL_ILACE  = 1;
    localparam int unsigned HIW_STAT_FIELD  = 31;
    localparam int unsigned HIW_STAT_ACTIVE = 30;
    localparam int unsigned HIW_ANC_ALIGN   = 8;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [10:0] HIW_FIELD_RST    = 11'h000;
    localparam logic [1:0]  HIW_CTRL_RST     = 2'h0;
    localparam logic [10:0] HIW_LINE_LEN_RST = 11'h7FF;
    localparam logic [10:0] HIW_LINE_CNT_RST = 11'h001;
    localparam logic [10:0] HIW_PIX_CNT_RST  = 11'h000;
    localparam logic [7:0]  HIW_BYTE_RST     = 8'h00;
    localparam logic [31:0] HIW_WORD_RST     = 32'h0000_0000;

    // ************************************************************
    // Channel state
    // ************************************************************
    typedef enum logic [1:0] {
        HIW_ST_IDLE   = 2'b00,
        HIW_ST_TOP    = 2'b01,
        HIW_ST_BOTTOM = 2'b11
    } hiw_state_t;

endpackage

`default_nettype wire

// ==== core/hiw_span_check.sv ====
// Span comparator: tells whether a counter lies in [start, start + size).
`default_nettype none

module hiw_span_check #(
    parameter int unsigned W = 11
) (
    input  wire logic [W-1:0] count,
    input  wire logic [W-1:0] start,
    input  wire logic [W-1:0] size,
    output logic              hit
);

    logic [W:0] offset;

    // The offset is one bit wider so start + size may pass the counter range.
    always_comb begin
        offset = {1'b0, count} - {1'b0, start};
        hit    = (count >= start) && (offset < {1'b0, size});
    end

endmodule

`default_nettype wire

// ==== verification/hiw_hanc_window_checker.sv ====
// Port checker for the ancillary insertion window, bound to the block.
`default_nettype none

module hiw_hanc_window_checker
    import hiw_pkg::*;
#(
    parameter int unsigned FLD_W = 11
) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic [7:0]       paddr,
    input wire logic             pslverr,
    input wire logic [7:0]       vid_byte,
    input wire logic             vid_valid,
    input wire logic [7:0]       anc_byte,
    input wire logic             anc_ready,
    input wire logic [7:0]       out_byte,
    input wire logic             out_valid,
    input wire logic             out_is_anc,
    input wire logic             field_bottom,
    input wire logic [FLD_W-1:0] line_count,
    input wire logic [FLD_W-1:0] pixel_count
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic bad_addr;
    assign bad_addr = (paddr[1:0] != 2'h0) || (paddr > 8'h18);

    property p_err;
        psel && penable |-> pslverr == bad_addr;
    endproperty
    property p_outv;
        vid_valid |=> out_valid;
    endproperty
    property p_anc;
        anc_ready |=> out_is_anc && out_byte == $past(anc_byte);
    endproperty
    property p_pass;
        vid_valid && !anc_ready |=> !out_is_anc && out_byte == $past(vid_byte);
    endproperty
    property p_gate;
        anc_ready |-> vid_valid;
    endproperty
    property p_pix;
        $changed(pixel_count) && pixel_count != '0 |-> pixel_count == $past(pixel_count) + 1;
    endproperty
    property p_line;
        $changed(line_count) && line_count != 1 |->
            line_count == $past(line_count) + 1 && pixel_count == '0;
    endproperty
    property p_fld;
        $changed(field_bottom) |-> line_count == 1 && pixel_count == '0;
    endproperty

    a_err:  assert property (p_err)  else $error("bus error flag wrong");
    a_outv: assert property (p_outv) else $error("output strobe missing");
    a_anc:  assert property (p_anc)  else $error("ancillary byte not emitted");
    a_pass: assert property (p_pass) else $error("video byte not passed");
    a_gate: assert property (p_gate) else $error("ancillary taken without video");
    a_pix:  assert property (p_pix)  else $error("pixel counter skipped");
    a_line: assert property (p_line) else $error("line counter skipped");
    a_fld:  assert property (p_fld)  else $error("field changed off frame end");

    c_anc:  cover property (anc_ready);
    c_fld:  cover property ($rose(field_bottom));
    c_err:  cover property (pslverr);
endmodule

bind hiw_hanc_window hiw_hanc_window_checker #(.FLD_W(FLD_W)) i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pslverr(pslverr), .vid_byte(vid_byte), .vid_valid(vid_valid),
    .anc_byte(anc_byte), .anc_ready(anc_ready), .out_byte(out_byte),
    .out_valid(out_valid), .out_is_anc(out_is_anc), .field_bottom(field_bottom),
    .line_count(line_count), .pixel_count(pixel_count)
);

`default_nettype wire

// ==== verification/hiw_hanc_window_tb.sv ====
// Self-checking bench of the ancillary insertion window block.
`default_nettype none

module hiw_hanc_window_tb
    import hiw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic [7:0] a; logic [31:0] rst; logic [31:0] rb; logic err;} hiw_row_t;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, vid_byte, anc_byte, out_byte, last_byte, prev_b;
    logic [31:0] pwdata, prdata, rd;
    logic        vid_valid, anc_ready, out_valid, out_is_anc, field_bottom;
    logic [10:0] line_count, pixel_count, ln, px;
    logic [15:0] anc_count;
    logic        er, fld, hit, prev_hit;
    int          bad_count, checks;
    hiw_row_t    rows [8];

    hiw_hanc_window i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .vid_byte(vid_byte), .vid_valid(vid_valid),
        .anc_byte(anc_byte), .anc_ready(anc_ready), .out_byte(out_byte),
        .out_valid(out_valid), .out_is_anc(out_is_anc), .field_bottom(field_bottom),
        .line_count(line_count), .pixel_count(pixel_count)
    );
    hiw_video_sink i_sink (
        .pclk(pclk), .presetn(presetn), .out_byte(out_byte), .out_valid(out_valid),
        .out_is_anc(out_is_anc), .anc_count(anc_count), .last_byte(last_byte)
    );

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // A wait for the slave's answer ends on pready; only the watchdog ends one that never comes.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // Window as programmed below: top lines 2-3 pixels 8-15, bottom lines 3-4 pixels 0-7.
    function automatic logic win(input logic f, input logic [10:0] l, input logic [10:0] p);
        logic [10:0] ls, ps;
        ls = f ? 11'h3 : 11'h2;
        ps = f ? 11'h0 : 11'h8;
        return (l >= ls) && (l < ls + 11'h2) && (p >= ps) && (p < ps + 11'h8);
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Stimulus
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    initial begin
        repeat (3000) @(posedge pclk);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; vid_valid = 1'b0; vid_byte = 8'h00; anc_byte = 8'h00;
        bad_count = 0; checks = 0; prev_hit = 1'b0; prev_b = 8'h00;
        rows = '{
            '{HIW_OFF_VSIZE,     32'h0, 32'h0000_07FF, 1'b0},
            '{HIW_OFF_TOP_START, 32'h0, 32'h07FF_07FF, 1'b0},
            '{HIW_OFF_TOP_SIZE,  32'h0, 32'h07FF_07FF, 1'b0},
            '{HIW_OFF_BOT_START, 32'h0, 32'h07FF_07FF, 1'b0},
            '{HIW_OFF_STATUS, 32'h0001_0000, 32'h0001_0000, 1'b0},
            '{HIW_OFF_CTRL,      32'h0, 32'h0000_0003, 1'b0},
            '{HIW_OFF_LINE_LEN, 32'h7FF, 32'h0000_07FF, 1'b0},
            '{8'h1C,             32'h0, 32'h0, 1'b1}};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0);
            chk("reset value", rows[i].rst, rd);
            apb(1'b1, rows[i].a, 32'hFFFF_FFFF);
            chk("error flag", 32'(rows[i].err), 32'(er));
            apb(1'b0, rows[i].a, 32'h0);
            chk("readback", rows[i].rb, rd);
        end
        apb(1'b1, HIW_OFF_VSIZE, 32'h0000_0004);
        apb(1'b1, HIW_OFF_LINE_LEN, 32'h0000_000F);
        apb(1'b1, HIW_OFF_TOP_START, 32'h0002_0008);
        apb(1'b1, HIW_OFF_TOP_SIZE, 32'h0002_0008);
        apb(1'b1, HIW_OFF_BOT_START, 32'h0003_0000);
        fld = 1'b0; ln = 11'h1; px = 11'h0;
        // Two interlaced fields plus one line, so the field wraps back to top.
        for (int i = 0; i < 145; i++) begin
            @(posedge pclk);
            vid_valid <= (i < 144); vid_byte <= i[7:0]; anc_byte <= ~i[7:0];
            @(negedge pclk);
            if (i > 0) begin
                chk("anc flag", 32'(prev_hit), 32'(out_is_anc));
                chk("out byte", 32'(prev_b), 32'(out_byte));
                chk("out valid", 32'h1, 32'(out_valid));
            end
            if (i < 144) begin
                hit = win(fld, ln, px);
                chk("line", 32'(ln), 32'(line_count));
                chk("pixel", 32'(px), 32'(pixel_count));
                chk("field", 32'(fld), 32'(field_bottom));
                chk("anc ready", 32'(hit), 32'(anc_ready));
                prev_hit = hit;
                prev_b = hit ? ~i[7:0] : i[7:0];
                if (px == 11'hF) begin
                    px = 11'h0;
                    fld = (ln == 11'h4) ? ~fld : fld;
                    ln = (ln == 11'h4) ? 11'h1 : ln + 11'h1;
                end else begin
                    px = px + 11'h1;
                end
            end
        end
        chk("sink anc count", 32'h20, 32'(anc_count));
        chk("sink last byte", 32'h8E, 32'(last_byte));
        @(posedge pclk);
        vid_valid <= 1'b1;
        presetn <= 1'b0;
        @(negedge pclk);
        chk("reset line", 32'h1, 32'(line_count));
        chk("reset pixel", 32'h0, 32'(pixel_count));
        chk("reset anc ready", 32'h0, 32'(anc_ready));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        vid_valid <= 1'b0;
        apb(1'b0, HIW_OFF_TOP_START, 32'h0);
        chk("start after reset", 32'h0, rd);
        @(posedge pclk);
        vid_valid <= 1'b1; vid_byte <= 8'hA5; anc_byte <= 8'h5A;
        @(posedge pclk);
        vid_valid <= 1'b0;
        @(negedge pclk);
        chk("disabled byte", 32'hA5, 32'(out_byte));
        chk("disabled flag", 32'h0, 32'(out_is_anc));
        // Progressive mode: a frame wrap must leave the channel in the top field.
        apb(1'b1, HIW_OFF_LINE_LEN, 32'h0);
        apb(1'b1, HIW_OFF_CTRL, 32'h1);
        @(posedge pclk);
        vid_valid <= 1'b1;
        @(posedge pclk);
        vid_valid <= 1'b0;
        @(negedge pclk);
        chk("progressive field", 32'h0, 32'(field_bottom));
        chk("progressive line", 32'h1, 32'(line_count));
        chk("progressive pixel", 32'h0, 32'(pixel_count));
        tally_and_finish();
    end
endmodule

`default_nettype wire

// ==== verification/hiw_video_sink.sv ====
// Video sink model that tallies ancillary bytes leaving the channel.
`default_nettype none

module hiw_video_sink (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  out_byte,
    input  wire logic        out_valid,
    input  wire logic        out_is_anc,
    output logic      [15:0] anc_count,
    output logic      [7:0]  last_byte
);
    timeunit 1ns;
    timeprecision 1ps;

    // The sink never stalls: the stream has no back-pressure path.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            anc_count <= 16'h0;
            last_byte <= 8'h00;
        end else if (out_valid) begin
            last_byte <= out_byte;
            if (out_is_anc) begin
                anc_count <= anc_count + 16'h1;
            end
        end
    end
endmodule

`default_nettype wire
